/* inc/ucs_consts.svh */
`ifndef UCS_CONSTS_SVH
`define UCS_CONSTS_SVH

// ---------------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ---------------------------------------------------------------------------
`define UCS_A_CTRL        5'h00
`define UCS_A_VOL         5'h04
`define UCS_A_BEEP        5'h08
`define UCS_A_TIME        5'h0C
`define UCS_A_POR         5'h10
`define UCS_A_STAT        5'h14

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define UCS_C_STYLE       0
`define UCS_C_JUMP        1
`define UCS_C_PU1         2
`define UCS_C_PU2         3
`define UCS_C_HOLD_LO     4
`define UCS_C_HOLD_HI     5
`define UCS_C_ROCK_LO     6
`define UCS_C_ROCK_HI     7
`define UCS_C_SHORTMEM    8
`define UCS_C_VLD_LO      10
`define UCS_C_VLD_HI      15
`define UCS_V_EN          0
`define UCS_V_STEP_LO     1
`define UCS_V_STEP_HI     2
`define UCS_V_RNG_LO      3
`define UCS_V_RNG_HI      8
`define UCS_V_DEF_LO      9
`define UCS_V_DEF_HI      14
`define UCS_B_STEP_EN     0
`define UCS_B_SFRQ_LO     1
`define UCS_B_SFRQ_HI     4
`define UCS_B_SLVL_LO     5
`define UCS_B_SLVL_HI     8
`define UCS_B_LIM_EN      9
`define UCS_B_LFRQ_LO     10
`define UCS_B_LFRQ_HI     13
`define UCS_B_LLVL_LO     14
`define UCS_B_LLVL_HI     17

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define UCS_RST_CTRL      32'h0000_0400
`define UCS_RST_VOL       32'h0000_3181
`define UCS_RST_BEEP      32'h0000_0000
`define UCS_RST_TIME      32'h0000_01F4
`define UCS_RST_POR       32'h0000_000A

// ---------------------------------------------------------------------------
// Limits and timing
// ---------------------------------------------------------------------------
`define UCS_NUM_MEM       6
`define UCS_MEM_D         3'h3
`define UCS_VOL_MAX_DB    6'h30
`define UCS_CLK_NS        5
`define UCS_TICK_NS       1000000
`define UCS_TICK_CYC      (`UCS_TICK_NS / `UCS_CLK_NS)
`define UCS_HOLD1_MS      1500
`define UCS_HOLD2_MS      3500
`define UCS_HOLD3_MS      5500
`define UCS_POR_UNIT_MS   100

`endif

/* inc/ucs_pkg.sv */
`include "ucs_consts.svh"

package ucs_pkg;

   // Rocker switch personalities.
   typedef enum logic [1:0] {
      UCS_ROCK_VOL,
      UCS_ROCK_MEM,
      UCS_ROCK_MIX
   } ucs_rock_t;

   // State of one switch conditioner.
   typedef struct packed {
      logic lvl;
      logic prs;
      logic unp;
   } ucs_cond_t;

   // Whole state of the switch controller.
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] vcfg;
      logic [31:0] bcfg;
      logic [31:0] tcfg;
      logic [31:0] pcfg;
      logic [31:0] rdata;
      logic [17:0] tick_cnt;
      logic [15:0] por_ms;
      logic        por_done;
      logic [2:0]  mem;
      logic [2:0]  saved;
      logic        in_tel;
      logic [12:0] hold_ms;
      logic [5:0]  vol;
      logic        pressing;
      logic        press_up;
      logic [15:0] press_ms;
      logic        beep_start;
      logic [1:0]  beep_count;
      logic [3:0]  beep_freq;
      logic [3:0]  beep_level;
   } ucs_state_t;

endpackage : ucs_pkg

/* logic/ucs_sw_cond.sv */
`timescale 1ns/1ps

// Turns one switch pin into an active level and one-cycle press and
// release pulses, folding in the pull-up or pull-down bias choice.
module ucs_sw_cond
   import ucs_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic pin,
   input  wire logic pull_up,
   output logic      level,
   output logic      press,
   output logic      unpress
);

   ucs_cond_t s;
   ucs_cond_t next_s;
   logic      act;

   // With a pull-up bias a closed switch pulls the pin low.
   assign act = pin ^ pull_up;

   // Edge detection gives exactly one pulse per closure.
   always_comb begin
      next_s     = s;
      next_s.lvl = act;
      next_s.prs = act & ~s.lvl;
      next_s.unp = ~act & s.lvl;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign level   = s.lvl;
   assign press   = s.prs;
   assign unpress = s.unp;

endmodule : ucs_sw_cond

/* logic/ucs_switch_ctrl.sv */
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps

// Summary of operation
// - Momentary mode starts in memory A; each button press loads next valid.
// - A press while in the last valid memory wraps back to memory A.
// - Six memories; A always valid; invalid memories are skipped.
// - Plain momentary stepping with momentary style and jump disabled.
// - Select inputs share one momentary or static style; each is pull-up or pull-down.
// - With telecoil jump, closing the second select switch selects D.
// - Leaving D waits 1.5, 3.5 or 5.5 s after opening, or none.
// - Up pin closure raises gain one step; down pin lowers one step.
// - Up pin at supply steps volume up; down pin at supply steps down.
// - Stepped volume has an enable and a 1 to 4 dB step.
// - Volume range programmable 0 to 48 dB in 1 dB units.
// - At power-up the programmed default volume becomes current.
// - Each volume step may beep with programmed tone and loudness.
// - Stepping past a range limit gives two limit beeps if enabled.
// - Rocker works as volume only, memory select only, or mixed.
// - Mixed rocker splits short and long presses by a threshold.
// - Momentary presses are ignored during the power-on delay.
module ucs_switch_ctrl
   import ucs_pkg::*;
#(
   parameter logic [17:0] TICK_CYC = 18'(`UCS_TICK_CYC)
)
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        primary_select_line,
   input  wire logic        secondary_select_line,
   input  wire logic        volume_up_pin,
   input  wire logic        volume_down_pin,
   input  wire logic [4:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   output logic [2:0]       memory_sel,
   output logic [5:0]       volume_db,
   output logic             audio_enable,
   output logic             beep_start,
   output logic [1:0]       beep_count,
   output logic [3:0]       beep_freq,
   output logic [3:0]       beep_level
);

   // -------------------------------------------------------------------
   // Switch conditioning
   // -------------------------------------------------------------------
   ucs_state_t s;
   ucs_state_t next_s;
   logic       p_lvl, p_prs;
   logic       t_lvl, t_prs;
   logic       u_lvl, u_prs, u_unp;
   logic       d_lvl, d_prs, d_unp;

   // Select lines honour the programmed bias; volume pins are high-true.
   ucs_sw_cond u_prim (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pin     (primary_select_line),
      .pull_up (s.ctrl[`UCS_C_PU1]),
      .level   (p_lvl),
      .press   (p_prs),
      .unpress ()
   );

   ucs_sw_cond u_sec (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pin     (secondary_select_line),
      .pull_up (s.ctrl[`UCS_C_PU2]),
      .level   (t_lvl),
      .press   (t_prs),
      .unpress ()
   );

   ucs_sw_cond u_up (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pin     (volume_up_pin),
      .pull_up (1'b0),
      .level   (u_lvl),
      .press   (u_prs),
      .unpress (u_unp)
   );

   ucs_sw_cond u_dn (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pin     (volume_down_pin),
      .pull_up (1'b0),
      .level   (d_lvl),
      .press   (d_prs),
      .unpress (d_unp)
   );

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------

   // Next valid memory after cur; falls back to A when none is left.
   function automatic logic [2:0] ucs_next_mem(
      input logic [2:0]             cur,
      input logic [`UCS_NUM_MEM-1:0] vld,
      input logic                   skip_d
   );
      logic [2:0] r;
      logic       hit;
      r   = 3'h0;
      hit = 1'b0;
      for (int i = 1; i < `UCS_NUM_MEM; i++) begin
         if (!hit && i > int'(cur) && vld[i] &&
             !(skip_d && 3'(i) == `UCS_MEM_D)) begin
            r   = 3'(i);
            hit = 1'b1;
         end
      end
      return r;
   endfunction : ucs_next_mem

   logic                    tick;
   logic [`UCS_NUM_MEM-1:0] vld;
   logic                    style_static;
   logic                    jump;
   logic [5:0]              rng;
   logic [5:0]              dflt;
   logic [2:0]              step;
   logic [6:0]              vsum;
   logic [12:0]             hold_lim;
   logic [2:0]              stat_mem;
   logic [15:0]             por_lim;
   ucs_rock_t               rock;

   assign tick         = (s.tick_cnt == TICK_CYC - 18'h1);
   // Memory A cannot be switched off.
   assign vld          = {s.ctrl[`UCS_C_VLD_HI:`UCS_C_VLD_LO+1], 1'b1};
   assign style_static = s.ctrl[`UCS_C_STYLE];
   assign jump         = s.ctrl[`UCS_C_JUMP];
   assign step = {1'b0, s.vcfg[`UCS_V_STEP_HI:`UCS_V_STEP_LO]} + 3'h1;
   // Programmed range beyond 48 dB is clipped rather than trusted.
   assign rng  = (s.vcfg[`UCS_V_RNG_HI:`UCS_V_RNG_LO] > `UCS_VOL_MAX_DB)
               ? `UCS_VOL_MAX_DB
               : s.vcfg[`UCS_V_RNG_HI:`UCS_V_RNG_LO];
   assign dflt = (s.vcfg[`UCS_V_DEF_HI:`UCS_V_DEF_LO] > rng)
               ? rng : s.vcfg[`UCS_V_DEF_HI:`UCS_V_DEF_LO];
   assign por_lim = 16'(s.pcfg[7:0]) * 16'(`UCS_POR_UNIT_MS);

   // Telecoil hold time in ms; code zero leaves memory D at once.
   always_comb begin
      case (s.ctrl[`UCS_C_HOLD_HI:`UCS_C_HOLD_LO])
         2'h1:    hold_lim = 13'(`UCS_HOLD1_MS);
         2'h2:    hold_lim = 13'(`UCS_HOLD2_MS);
         2'h3:    hold_lim = 13'(`UCS_HOLD3_MS);
         default: hold_lim = 13'h0000;
      endcase
   end

   // Static switches: 2 bits pick a memory, invalid ones give A.
   always_comb begin
      case ({t_lvl, p_lvl})
         2'b01:   stat_mem = 3'h1;
         2'b10:   stat_mem = jump ? `UCS_MEM_D : 3'h2;
         2'b11:   stat_mem = `UCS_MEM_D;
         default: stat_mem = 3'h0;
      endcase
      if (!vld[stat_mem] && !(jump && t_lvl)) begin
         stat_mem = 3'h0;
      end
   end

   // Unknown rocker codes behave as plain volume control.
   always_comb begin
      case (s.ctrl[`UCS_C_ROCK_HI:`UCS_C_ROCK_LO])
         2'h1:    rock = UCS_ROCK_MEM;
         2'h2:    rock = UCS_ROCK_MIX;
         default: rock = UCS_ROCK_VOL;
      endcase
   end

   // -------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------
   always_comb begin
      logic mem_evt;
      logic up_evt;
      logic dn_evt;
      logic lng;
      logic at_lim;
      mem_evt = 1'b0;
      up_evt  = 1'b0;
      dn_evt  = 1'b0;
      lng     = 1'b0;
      at_lim  = 1'b0;
      vsum    = 7'h00;
      next_s  = s;
      next_s.beep_start = 1'b0;
      next_s.rdata      = 32'h0000_0000;

      // Register writes; unmapped addresses are ignored.
      if (reg_wr) begin
         case (reg_addr)
            `UCS_A_CTRL: next_s.ctrl = reg_wdata;
            `UCS_A_VOL:  next_s.vcfg = reg_wdata;
            `UCS_A_BEEP: next_s.bcfg = reg_wdata;
            `UCS_A_TIME: next_s.tcfg = reg_wdata;
            `UCS_A_POR:  next_s.pcfg = reg_wdata;
            default: ;
         endcase
      end

      // Read data stands for the one cycle after the strobe only.
      if (reg_rd) begin
         case (reg_addr)
            `UCS_A_CTRL: next_s.rdata = s.ctrl;
            `UCS_A_VOL:  next_s.rdata = s.vcfg;
            `UCS_A_BEEP: next_s.rdata = s.bcfg;
            `UCS_A_TIME: next_s.rdata = s.tcfg;
            `UCS_A_POR:  next_s.rdata = s.pcfg;
            `UCS_A_STAT: next_s.rdata = {21'h0, s.in_tel, s.por_done,
                                         s.vol, s.mem};
            default:     next_s.rdata = 32'h0000_0000;
         endcase
      end

      // Millisecond time base shared by all timers.
      next_s.tick_cnt = tick ? 18'h0 : s.tick_cnt + 18'h1;

      // Power-on delay: volume follows the programmed default until
      // audio opens, so late configuration still takes effect.
      if (!s.por_done) begin
         next_s.vol = dflt;
         if (s.por_ms >= por_lim) begin
            next_s.por_done = 1'b1;
         end else if (tick) begin
            next_s.por_ms = s.por_ms + 16'h1;
         end
      end

      // Rocker events; presses during the delay are dropped whole.
      if (s.por_done) begin
         case (rock)
            UCS_ROCK_MEM: begin
               mem_evt = u_prs | d_prs;
            end
            UCS_ROCK_MIX: begin
               // Classification happens on release, so a long press
               // acts only once the finger lifts.
               if (!s.pressing && (u_prs || d_prs)) begin
                  next_s.pressing = 1'b1;
                  next_s.press_up = u_prs;
                  next_s.press_ms = 16'h0;
               end else if (s.pressing) begin
                  if (tick && s.press_ms != 16'hFFFF) begin
                     next_s.press_ms = s.press_ms + 16'h1;
                  end
                  if ((s.press_up && u_unp) || (!s.press_up && d_unp)) begin
                     next_s.pressing = 1'b0;
                     lng = (s.press_ms >= s.tcfg[15:0]);
                     if (lng ^ s.ctrl[`UCS_C_SHORTMEM]) begin
                        mem_evt = 1'b1;
                     end else begin
                        up_evt = s.press_up;
                        dn_evt = ~s.press_up;
                     end
                  end
               end
            end
            default: begin
               up_evt = u_prs;
               dn_evt = d_prs;
            end
         endcase
         if (!style_static) begin
            mem_evt = mem_evt | p_prs;
         end
      end

      // Telecoil jump: memory D while closed, held after opening.
      if (jump && t_lvl) begin
         if (!s.in_tel) begin
            next_s.saved = s.mem;
         end
         next_s.in_tel  = 1'b1;
         next_s.mem     = `UCS_MEM_D;
         next_s.hold_ms = 13'h0000;
      end else if (s.in_tel) begin
         if (s.hold_ms >= hold_lim) begin
            next_s.in_tel = 1'b0;
            next_s.mem    = style_static ? stat_mem : s.saved;
         end else if (tick) begin
            next_s.hold_ms = s.hold_ms + 13'h1;
         end
      end else if (style_static) begin
         next_s.mem = stat_mem;
      end else if (mem_evt) begin
         // D is reserved for the telecoil in jump mode.
         next_s.mem = ucs_next_mem(s.mem, vld, jump);
      end

      // Volume stepping saturates at the range ends.
      if (s.vcfg[`UCS_V_EN] && (up_evt || dn_evt)) begin
         if (up_evt) begin
            at_lim = (s.vol >= rng);
            vsum   = {1'b0, s.vol} + {4'h0, step};
            next_s.vol = (vsum > {1'b0, rng}) ? rng : vsum[5:0];
         end else begin
            at_lim = (s.vol == 6'h00);
            next_s.vol = (s.vol > {3'h0, step})
                       ? s.vol - {3'h0, step} : 6'h00;
         end
         if (at_lim) begin
            next_s.vol = s.vol;
            if (s.bcfg[`UCS_B_LIM_EN]) begin
               next_s.beep_start = 1'b1;
               next_s.beep_count = 2'h2;
               next_s.beep_freq  = s.bcfg[`UCS_B_LFRQ_HI:`UCS_B_LFRQ_LO];
               next_s.beep_level = s.bcfg[`UCS_B_LLVL_HI:`UCS_B_LLVL_LO];
            end
         end else if (s.bcfg[`UCS_B_STEP_EN]) begin
            next_s.beep_start = 1'b1;
            next_s.beep_count = 2'h1;
            next_s.beep_freq  = s.bcfg[`UCS_B_SFRQ_HI:`UCS_B_SFRQ_LO];
            next_s.beep_level = s.bcfg[`UCS_B_SLVL_HI:`UCS_B_SLVL_LO];
         end
      end
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s      <= '0;
         s.ctrl <= `UCS_RST_CTRL;
         s.vcfg <= `UCS_RST_VOL;
         s.bcfg <= `UCS_RST_BEEP;
         s.tcfg <= `UCS_RST_TIME;
         s.pcfg <= `UCS_RST_POR;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata    = s.rdata;
   assign memory_sel   = s.mem;
   assign volume_db    = s.vol;
   assign audio_enable = s.por_done;
   assign beep_start   = s.beep_start;
   assign beep_count   = s.beep_count;
   assign beep_freq    = s.beep_freq;
   assign beep_level   = s.beep_level;

endmodule : ucs_switch_ctrl

/* tb/ucs_switch_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Switches held by the wearer
// ----------------------------------------------------------------------
// An open select contact rests at its bias level.
module ucs_switch_model
(
   input  wire logic ref_clk,
   input  wire logic pull_up1,
   input  wire logic pull_up2,
   output logic      primary_select_line,
   output logic      secondary_select_line,
   output logic      volume_up_pin,
   output logic      volume_down_pin
);
   logic [3:0] closed = 4'h0;

   // A closed select contact pulls the pin against its bias.
   assign primary_select_line   = closed[0] ^ pull_up1;
   assign secondary_select_line = closed[1] ^ pull_up2;
   // The toggle ties the up pin to the supply for up, the down pin to the supply for down.
   assign volume_up_pin   = closed[2];
   assign volume_down_pin = closed[3];

   // Keep one contact closed for len cycles, then let it rest open.
   task automatic press(input int idx, input int len);
      closed[idx] <= 1'b1;
      repeat (len) @(posedge ref_clk);
      closed[idx] <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask : press
endmodule : ucs_switch_model

/* tb/ucs_switch_checker.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module ucs_switch_checker
   import ucs_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       volume_up_pin,
   input wire logic       volume_down_pin,
   input wire logic [2:0] memory_sel,
   input wire logic [5:0] volume_db,
   input wire logic       audio_enable,
   input wire logic       beep_start,
   input wire logic [1:0] beep_count
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Volume may only rise or fall just after the matching contact.
   property p_up_cause;
      $past(audio_enable, 2) && volume_db > $past(volume_db)
         |-> $past(volume_up_pin) || $past(volume_up_pin, 2)
             || $past(volume_up_pin, 3) || $past(volume_up_pin, 4);
   endproperty
   property p_dn_cause;
      $past(audio_enable, 2) && volume_db < $past(volume_db)
         |-> $past(volume_down_pin) || $past(volume_down_pin, 2)
             || $past(volume_down_pin, 3) || $past(volume_down_pin, 4);
   endproperty
   property p_mem_range;  memory_sel < 3'h6;  endproperty
   property p_vol_max;    volume_db <= 6'h30;  endproperty
   property p_por_quiet;
      !audio_enable |-> $stable(memory_sel) && !beep_start;
   endproperty
   property p_audio_stay; audio_enable |=> audio_enable; endproperty
   property p_beep_code;
      beep_start |-> beep_count == 2'h1 || beep_count == 2'h2;
   endproperty
   property p_step_beep;
      beep_start && beep_count == 2'h1 |-> volume_db != $past(volume_db);
   endproperty
   property p_limit_beep;
      beep_start && beep_count == 2'h2 |-> $stable(volume_db);
   endproperty

   a_up_cause: assert property (p_up_cause)
      else $error("volume rose without an up closure");
   a_dn_cause: assert property (p_dn_cause)
      else $error("volume fell without a down closure");
   a_mem_range: assert property (p_mem_range)
      else $error("memory out of range");
   a_vol_max: assert property (p_vol_max)
      else $error("volume above range");
   a_por_quiet: assert property (p_por_quiet)
      else $error("activity before audio");
   a_audio_stay: assert property (p_audio_stay)
      else $error("audio enable dropped");
   a_beep_code: assert property (p_beep_code)
      else $error("beep with an unknown count");
   a_step_beep: assert property (p_step_beep)
      else $error("step beep without a volume change");
   a_limit_beep: assert property (p_limit_beep)
      else $error("limit beep while volume moved");

   c_limit: cover property (beep_start && beep_count == 2'h2);
   c_last:  cover property (memory_sel == 3'h5);
   c_tel:   cover property (memory_sel == 3'h3);
   c_top:   cover property (volume_db == 6'h30);
endmodule : ucs_switch_checker

bind ucs_switch_ctrl ucs_switch_checker chk_u (
   .ref_clk(ref_clk), .rst(rst), .volume_up_pin(volume_up_pin),
   .volume_down_pin(volume_down_pin), .memory_sel(memory_sel),
   .volume_db(volume_db), .audio_enable(audio_enable),
   .beep_start(beep_start), .beep_count(beep_count));

/* tb/user_control_switch_logic_bench.sv */
`timescale 1ns/1ps
`include "ucs_consts.svh"

module user_control_switch_logic_bench;
   import ucs_pkg::*;

   // A 1 ms tick of four cycles keeps the 5.5 s hold within the run.
   localparam int TK = 4;

   logic        ref_clk, rst, reg_wr, reg_rd, lim;
   logic        pu1 = 1'b0, pu2 = 1'b0;
   logic [4:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, seed, d, bcfg;
   logic [2:0]  memory_sel;
   logic [5:0]  volume_db, vld;
   logic        audio_enable, beep_start;
   logic [1:0]  beep_count;
   logic [3:0]  beep_freq, beep_level;
   wire         primary_select_line, secondary_select_line;
   wire         volume_up_pin, volume_down_pin;
   int          error_cnt, compares, beeps, n, k, s, em, ev, rng;
   int          hms[4] = '{0, 1500, 3500, 5500};
   // Status after reset: memory A, default volume 24, audio still off.
   logic [31:0] rv[6] = '{`UCS_RST_CTRL, `UCS_RST_VOL, `UCS_RST_BEEP,
                          `UCS_RST_TIME, `UCS_RST_POR, 32'h0000_00C0};

   ucs_switch_ctrl #(.TICK_CYC(18'(TK))) dut_u (.*);

   ucs_switch_model sw_u (
      .ref_clk(ref_clk), .pull_up1(pu1), .pull_up2(pu2),
      .primary_select_line(primary_select_line),
      .secondary_select_line(secondary_select_line),
      .volume_up_pin(volume_up_pin), .volume_down_pin(volume_down_pin));

   // ---------------------------------------------------------------------
   // Clock, bias tracking and beep counting
   // ---------------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // Bias follows the stored control word, so no false closure shows.
   always @(posedge ref_clk) begin
      if (reg_wr && reg_addr == `UCS_A_CTRL) {pu2, pu1} <= reg_wdata[3:2];
      if (beep_start === 1'b1) beeps <= beeps + 1;
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs

   // Next memory marked valid after c, wrapping to the first.
   function automatic int nxt(input int c, input logic [5:0] v);
      int j;
      j = c;
      for (int i = 0; i < 6; i++) begin
         j = (j + 1) % 6;
         if (v[j]) return j;
      end
      return 0;
   endfunction : nxt

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic cyc(input int c);
      repeat (c) @(posedge ref_clk);
   endtask : cyc

   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [31:0] v);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      @(posedge ref_clk);
   endtask : rd

   // One volume toggle; a step from the limit must give the double beep.
   task automatic vstep(input int idx);
      int b0;
      lim = (idx == 2) ? (ev == rng) : (ev == 0);
      b0  = beeps;
      sw_u.press(idx, 4);
      if (!lim && idx == 2) ev = (ev + s > rng) ? rng : ev + s;
      if (!lim && idx == 3) ev = (ev < s) ? 0 : ev - s;
      check(volume_db, ev);
      check(beeps, b0 + 1);
      check(beep_count, lim ? 2 : 1);
      check(beep_freq, lim ? bcfg[13:10] : bcfg[4:1]);
      check(beep_level, lim ? bcfg[17:14] : bcfg[8:5]);
   endtask : vstep

   // A rocker action is either a memory step or a volume step.
   task automatic rstep(input logic mem);
      if (mem) em = nxt(em, 6'h3f);
      else ev = (ev + s > rng) ? rng : ev + s;
      check(memory_sel, em);
      check(volume_db, ev);
   endtask : rstep

   task automatic stop_test();
      $display("error_cnt %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   // ---------------------------------------------------------------------
   // Watchdog and main sequence
   // ---------------------------------------------------------------------
   initial begin
      repeat (90000) @(posedge ref_clk);
      error_cnt++;
      stop_test();
   end

   initial begin
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      rst = 1'b1;
      seed = 32'h0000_004A;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      for (n = 0; n < 6; n++) begin
         rd(5'(4 * n), d);
         check(d, rv[n]);
      end
      // Presses during the power-on delay change nothing.
      wr(`UCS_A_POR, 32'h0000_0001);
      sw_u.press(0, 4);
      check(memory_sel, 0);
      check(volume_db, 24);
      for (n = 0; n < 5000 && audio_enable !== 1'b1; n++) @(posedge ref_clk);
      check(audio_enable, 1);
      // Momentary stepping over three sets of valid memories.
      em = 0;
      for (n = 0; n < 3; n++) begin
         seed = xs(seed);
         vld = (n == 0) ? 6'h01 : (n == 1) ? 6'h3f : {seed[4:0], 1'b1};
         wr(`UCS_A_CTRL, {16'h0, vld, 10'h0} | ((n == 2) ? 32'h4 : 32'h0));
         repeat (7) begin
            sw_u.press(0, 4);
            em = nxt(em, vld);
            check(memory_sel, em);
         end
      end
      // Telecoil entry, ignored presses, and each hold-off length.
      wr(`UCS_A_CTRL, 32'h0000_FC06);
      repeat (6) begin
         sw_u.press(0, 4);
         em = nxt(em, 6'h37);
         check(memory_sel, em);
      end
      for (n = 0; n < 4; n++) begin
         wr(`UCS_A_CTRL, 32'h0000_FC06 | (n << 4));
         sw_u.closed[1] <= 1'b1;
         cyc(8);
         check(memory_sel, 3);
         sw_u.press(0, 4);
         check(memory_sel, 3);
         sw_u.closed[1] <= 1'b0;
         if (n > 0) begin
            cyc(hms[n] * TK - 40);
            check(memory_sel, 3);
         end
         cyc(80);
         check(memory_sel, em);
      end
      // Stepped volume up to and down to each limit, every step size.
      wr(`UCS_A_CTRL, 32'h0000_FC04);
      ev = 24;
      for (s = 1; s <= 4; s++) begin
         seed = xs(seed);
         rng  = 24 + seed[20:16] % 25;
         bcfg = {14'h0, seed[17:0]} | 32'h0000_0201;
         wr(`UCS_A_VOL, {17'h0, 6'd24, 6'(rng), 2'(s - 1), 1'b1});
         wr(`UCS_A_BEEP, bcfg);
         do vstep(2); while (!lim);
         do vstep(3); while (!lim);
      end
      // With stepping disabled a closure is refused silently.
      wr(`UCS_A_VOL, {17'h0, 6'd24, 6'(rng), 3'b110});
      k = beeps;
      sw_u.press(2, 4);
      check(volume_db, ev);
      check(beeps, k);
      s = 4;
      wr(`UCS_A_VOL, {17'h0, 6'd24, 6'(rng), 3'b111});
      // Rocker as memory select, then mixed with both short-press meanings.
      wr(`UCS_A_CTRL, 32'h0000_FC44);
      sw_u.press(2, 4);
      rstep(1'b1);
      wr(`UCS_A_TIME, 32'h0000_000A);
      for (n = 0; n < 2; n++) begin
         wr(`UCS_A_CTRL, 32'h0000_FC84 | (n << 8));
         for (k = 0; k < 2; k++) begin
            sw_u.press(2, (k == 1) ? 100 : 8);
            rstep(1'(n ^ k));
         end
      end
      stop_test();
   end
endmodule : user_control_switch_logic_bench
